/* File: hw/rit_pkg.sv */
// Purpose: shared constants and types of the ram/io/timer combo
// Assumes: 8-bit processor bus sampled on the system clock
// Notes: offsets are the low address bits seen with ram_or_io_select high
package rit_pkg;
  localparam int RIT_DW = 8;
  localparam int RIT_AW = 7;
  localparam int RIT_RAM_WORDS = 128;
  // i/o register space, selected by address bits 1..0
  localparam logic [1:0] RIT_OFS_PORT_A_OUTPUT = 2'h0;
  localparam logic [1:0] RIT_OFS_PORT_A_DIRECTION = 2'h1;
  localparam logic [1:0] RIT_OFS_PORT_B_OUTPUT = 2'h2;
  localparam logic [1:0] RIT_OFS_PORT_B_DIRECTION = 2'h3;
  // timer side offsets, full 7-bit form
  localparam logic [6:0] RIT_OFS_EDGE_DETECT_CONTROL = 7'h04;
  localparam logic [6:0] RIT_OFS_INTERRUPT_FLAGS = 7'h05;
  localparam logic [6:0] RIT_OFS_INTERVAL_COUNTER = 7'h14;
  // address bit positions
  localparam int RIT_A_SIDE = 2;
  localparam int RIT_A_TIEN = 3;
  localparam int RIT_A_LOAD = 4;
  localparam int RIT_A_EIEN = 1;
  localparam int RIT_A_EPOL = 0;
  localparam int RIT_A_FLAGRD = 0;
  // flag register layout and the edge sense pin
  localparam int RIT_FLAG_TIMER = 7;
  localparam int RIT_FLAG_EDGE = 6;
  localparam int RIT_EDGE_PIN = 7;
  // prescaler terminal values (divide minus one)
  localparam logic [9:0] RIT_PRE_LAST_1 = 10'h000;
  localparam logic [9:0] RIT_PRE_LAST_8 = 10'h007;
  localparam logic [9:0] RIT_PRE_LAST_64 = 10'h03F;
  localparam logic [9:0] RIT_PRE_LAST_1024 = 10'h3FF;
  // reset values and the count loaded after a timeout
  localparam logic [7:0] RIT_RST_PORT = 8'h00;
  localparam logic [7:0] RIT_RST_COUNT = 8'hFF;
  localparam logic [7:0] RIT_COUNT_AFTER = 8'hFF;
  localparam logic [1:0] RIT_RST_DIV = 2'h0;
  localparam logic RIT_RST_EPOL = 1'b0;
  typedef enum logic [1:0] {
    RIT_TGT_NONE,
    RIT_TGT_RAM,
    RIT_TGT_IO,
    RIT_TGT_TIMER
  } rit_tgt_t;
endpackage

/* File: hw/rit_ram.sv */
// Purpose: 128 x 8 scratch memory with registered read data
// Assumes: one access per clock, a read in the same clock as a write returns the old word
// Notes: contents are not cleared by reset
module rit_ram
  import rit_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [RIT_AW-1:0] addr,
  input wire logic [RIT_DW-1:0] wdata,
  output logic [RIT_DW-1:0] rdata
);
  logic [RIT_DW-1:0] mem [RIT_RAM_WORDS];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end
endmodule

/* File: hw/rit_top.sv */
// Purpose: ram, two i/o ports, interval timer and edge sense interrupt
// Assumes: one bus access per selected clock, bus inputs on clk
// Notes: read data appear one edge after the access is taken
module rit_top
  import rit_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic select_high_active,
  input wire logic select_low_active,
  input wire logic ram_or_io_select,
  input wire logic rw,
  input wire logic [RIT_AW-1:0] address_lines,
  input wire logic [RIT_DW-1:0] data_in,
  output logic [RIT_DW-1:0] data_out,
  output logic data_oe,
  input wire logic [RIT_DW-1:0] first_port_pins_in,
  output logic [RIT_DW-1:0] first_port_pins_out,
  output logic [RIT_DW-1:0] first_port_pins_oe,
  input wire logic [RIT_DW-1:0] second_port_pins_in,
  output logic [RIT_DW-1:0] second_port_pins_out,
  output logic [RIT_DW-1:0] second_port_pins_oe,
  output logic irq_out,
  output logic irq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] ora;
    logic [7:0] first_port_direction;
    logic [7:0] orb;
    logic [7:0] port_b_direction;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic pa7_prev;
    logic [7:0] cnt;
    logic [9:0] pre;
    logic [1:0] div;
    logic fast;
    logic tflag;
    logic tien;
    logic eflag;
    logic eien;
    logic epol;
    logic rd_ram;
    logic rd_reg;
    logic [7:0] rdat;
    logic [7:0] dout;
    logic doe;
    logic irq_oe;
  } rit_state_t;

  rit_state_t st_ff;
  rit_state_t nxt_st;

  function automatic rit_tgt_t rit_decode(input logic hi, input logic lo,
                                          input logic rs,
                                          input logic [RIT_AW-1:0] a);
    if (!hi || lo) begin
      rit_decode = RIT_TGT_NONE;
    end else if (!rs) begin
      rit_decode = RIT_TGT_RAM;
    end else if (a[RIT_A_SIDE]) begin
      rit_decode = RIT_TGT_TIMER;
    end else begin
      rit_decode = RIT_TGT_IO;
    end
  endfunction

  function automatic logic [9:0] rit_pre_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: rit_pre_last = RIT_PRE_LAST_1;
      2'h1: rit_pre_last = RIT_PRE_LAST_8;
      2'h2: rit_pre_last = RIT_PRE_LAST_64;
      2'h3: rit_pre_last = RIT_PRE_LAST_1024;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  rit_tgt_t tgt;
  logic [RIT_DW-1:0] ram_rdata;
  logic ram_wr;
  logic ram_rd;
  logic io_wr;
  logic io_rd;
  logic tm_wr;
  logic tm_rd;
  logic ed_wr;
  logic fl_rd;
  logic tick;
  logic timeout;
  logic pa7_now;
  logic edge_hit;

  always_comb begin
    tgt = rit_decode(select_high_active, select_low_active,
                     ram_or_io_select, address_lines);
    ram_wr = (tgt == RIT_TGT_RAM) && !rw;
    ram_rd = (tgt == RIT_TGT_RAM) && rw;
    io_wr = (tgt == RIT_TGT_IO) && !rw;
    io_rd = (tgt == RIT_TGT_IO) && rw;
    tm_wr = (tgt == RIT_TGT_TIMER) && !rw && address_lines[RIT_A_LOAD];
    ed_wr = (tgt == RIT_TGT_TIMER) && !rw && !address_lines[RIT_A_LOAD];
    tm_rd = (tgt == RIT_TGT_TIMER) && rw && !address_lines[RIT_A_FLAGRD];
    fl_rd = (tgt == RIT_TGT_TIMER) && rw && address_lines[RIT_A_FLAGRD];
  end

  rit_ram u_ram (
    .clk(clk),
    .wr_en(ram_wr),
    .rd_en(ram_rd),
    .addr(address_lines),
    .wdata(data_in),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    // pins come from outside, two flops before use
    nxt_st.pa_s1 = first_port_pins_in;
    nxt_st.pa_s2 = st_ff.pa_s1;
    pa7_now = st_ff.pa_s2[RIT_EDGE_PIN];
    nxt_st.pa7_prev = pa7_now;
    // direction and enables do not gate the edge detector
    edge_hit = st_ff.epol ? (pa7_now && !st_ff.pa7_prev)
                          : (!pa7_now && st_ff.pa7_prev);

    // timer: prescaled until timeout, then every clock
    tick = st_ff.fast || (st_ff.pre == rit_pre_last(st_ff.div));
    timeout = tick && !st_ff.fast && (st_ff.cnt == 8'h00);
    nxt_st.pre = tick ? 10'h000 : st_ff.pre + 10'h001;
    if (timeout) begin
      nxt_st.cnt = RIT_COUNT_AFTER;
      nxt_st.fast = 1'b1;
    end else if (tick) begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end

    if (tm_wr || tm_rd) begin
      nxt_st.tien = address_lines[RIT_A_TIEN];
      nxt_st.tflag = 1'b0;
    end
    // a load restarts the prescaler so the first step is a full interval
    if (tm_wr) begin
      nxt_st.cnt = data_in;
      nxt_st.div = address_lines[1:0];
      nxt_st.pre = 10'h000;
      nxt_st.fast = 1'b0;
    end
    // a timeout coinciding with a read keeps the flag set, one with a load does not
    if (timeout && !tm_wr) begin
      nxt_st.tflag = 1'b1;
    end

    if (ed_wr) begin
      // data bus intentionally unused here
      nxt_st.eien = address_lines[RIT_A_EIEN];
      nxt_st.epol = address_lines[RIT_A_EPOL];
    end
    if (fl_rd) begin
      nxt_st.eflag = 1'b0;
    end
    if (edge_hit) begin
      nxt_st.eflag = 1'b1; // set wins over the read clear
    end

    if (io_wr) begin
      unique case (address_lines[1:0])
        RIT_OFS_PORT_A_OUTPUT: nxt_st.ora = data_in;
        RIT_OFS_PORT_A_DIRECTION: nxt_st.first_port_direction = data_in;
        RIT_OFS_PORT_B_OUTPUT: nxt_st.orb = data_in;
        RIT_OFS_PORT_B_DIRECTION: nxt_st.port_b_direction = data_in;
      endcase
    end

    // read path: capture, then drive the bus one edge later
    nxt_st.rd_ram = ram_rd;
    nxt_st.rd_reg = io_rd || tm_rd || fl_rd;
    nxt_st.rdat = 8'h00;
    if (io_rd) begin
      unique case (address_lines[1:0])
        RIT_OFS_PORT_A_OUTPUT: nxt_st.rdat = st_ff.pa_s2;
        RIT_OFS_PORT_A_DIRECTION: nxt_st.rdat = st_ff.first_port_direction;
        RIT_OFS_PORT_B_OUTPUT: nxt_st.rdat = st_ff.orb;
        RIT_OFS_PORT_B_DIRECTION: nxt_st.rdat = st_ff.port_b_direction;
      endcase
    end else if (tm_rd) begin
      nxt_st.rdat = st_ff.cnt;
    end else if (fl_rd) begin
      nxt_st.rdat[RIT_FLAG_TIMER] = st_ff.tflag;
      nxt_st.rdat[RIT_FLAG_EDGE] = st_ff.eflag;
    end
    // registered driver costs a cycle but keeps the bus free of glitches
    nxt_st.doe = st_ff.rd_ram || st_ff.rd_reg;
    nxt_st.dout = st_ff.rd_ram ? ram_rdata
                : (st_ff.rd_reg ? st_ff.rdat : 8'h00);

    // open drain request: enable pulls the line low
    nxt_st.irq_oe = (st_ff.tflag && st_ff.tien) ||
                    (st_ff.eflag && st_ff.eien);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.ora <= RIT_RST_PORT;
      st_ff.first_port_direction <= RIT_RST_PORT;
      st_ff.orb <= RIT_RST_PORT;
      st_ff.port_b_direction <= RIT_RST_PORT;
      st_ff.cnt <= RIT_RST_COUNT;
      st_ff.div <= RIT_RST_DIV;
      st_ff.eien <= 1'b0;
      st_ff.epol <= RIT_RST_EPOL;
      st_ff.pa_s1 <= 8'hFF;
      st_ff.pa_s2 <= 8'hFF;
      st_ff.pa7_prev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    data_out = st_ff.dout;
    data_oe = st_ff.doe;
    first_port_pins_out = st_ff.ora;
    first_port_pins_oe = st_ff.first_port_direction;
    second_port_pins_out = st_ff.orb;
    second_port_pins_oe = st_ff.port_b_direction;
    irq_out = 1'b0;
    irq_oe = st_ff.irq_oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic any_rd;
  assign any_rd = ram_rd || io_rd || tm_rd || fl_rd;

  chk_bus_drive: assert property (
    data_oe |-> $past(any_rd, 2))
    else $error("data bus driven without a read");
  chk_reset_quiet: assert property (
    disable iff (1'b0) !resetn |=> !data_oe && first_port_pins_oe == 8'h00
      && second_port_pins_oe == 8'h00 && !irq_oe)
    else $error("reset left outputs active");
  chk_dir_write: assert property (
    io_wr && address_lines[1:0] == RIT_OFS_PORT_A_DIRECTION
      |=> first_port_pins_oe == $past(data_in))
    else $error("direction write not applied");
  chk_pb_read: assert property (
    io_rd && address_lines[1:0] == RIT_OFS_PORT_B_OUTPUT && !io_wr
      |-> ##2 data_oe && data_out == $past(st_ff.orb, 2))
    else $error("port b read wrong");
  chk_flag_layout: assert property (
    fl_rd |-> ##2 data_out[5:0] == 6'h00
      && data_out[7] == $past(st_ff.tflag, 2))
    else $error("flag read layout wrong");
  chk_edge_cfg: assert property (
    ed_wr |=> st_ff.eien == $past(address_lines[1])
      && st_ff.epol == $past(address_lines[0]))
    else $error("edge control not taken from address");
  chk_timer_load: assert property (
    tm_wr |=> st_ff.cnt == $past(data_in)
      && st_ff.div == $past(address_lines[1:0]) && !st_ff.tflag)
    else $error("timer load wrong");
  chk_tien_addr: assert property (
    tm_wr || tm_rd |=> st_ff.tien == $past(address_lines[3]))
    else $error("timer enable not from address bit 3");
  chk_timeout_ones: assert property (
    timeout && !tm_wr |=> st_ff.cnt == 8'hFF && st_ff.tflag
      ##1 st_ff.cnt == 8'hFE || $past(tm_wr))
    else $error("timeout sequence wrong");
  chk_read_keeps: assert property (
    timeout && tm_rd |=> st_ff.tflag)
    else $error("coinciding read cleared timer flag");
  chk_edge_clear: assert property (
    fl_rd && !edge_hit |=> !st_ff.eflag)
    else $error("flag read did not clear edge flag");
  chk_irq_cause: assert property (
    irq_oe |-> $past(st_ff.tflag && st_ff.tien || st_ff.eflag && st_ff.eien))
    else $error("irq without enabled flag");
  chk_porta_pins: assert property (
    io_rd && address_lines[1:0] == RIT_OFS_PORT_A_OUTPUT
      |-> ##2 data_out == $past(st_ff.pa_s2, 2))
    else $error("port a read not from pins");
  chk_edge_set: assert property (
    edge_hit |=> st_ff.eflag)
    else $error("active edge did not set flag");
  chk_count_step: assert property (
    tick && !timeout && !tm_wr |=> st_ff.cnt == $past(st_ff.cnt) - 8'h01)
    else $error("counter did not step by one");
  chk_load_restart: assert property (
    tm_wr |=> st_ff.pre == 10'h000 && !st_ff.fast)
    else $error("load did not restart prescaler");
  chk_irq_timer: assert property (
    st_ff.tflag && st_ff.tien |=> irq_oe)
    else $error("enabled timer flag gave no request");

  cov_timeout: cover property (timeout);
  cov_edge_irq: cover property (edge_hit && st_ff.eien ##2 irq_oe);
  cov_ram_read: cover property (ram_rd ##2 data_oe);
  cov_read_timeout: cover property (timeout && tm_rd);
endmodule

/* File: tb/ram_io_timer_combo_tb.sv */
// Purpose: self-checking bench of the ram, ports, timer and edge sense
// Assumes: reference values come from integer models of each register
// Notes: timer counts are checked at mid-interval to tolerate latency
module ram_io_timer_combo_tb
  import rit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn;
  logic [7:0] pa_in, pb_in;
  logic shi, slo, rs, rw, oe, irq_oe, irq_o;
  logic [6:0] adr;
  logic [7:0] din, dout, pa_out, pa_oe, pb_out, pb_oe, q;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int regs[4];
  int mem[128];
  int dv[4] = '{1, 8, 64, 1024};
  int n, t0, a, pv;
  always #25 clk = ~clk;
  always @(posedge clk) cyc++;
  rit_top rit_top_i(.clk(clk), .resetn(resetn),
    .select_high_active(shi), .select_low_active(slo),
    .ram_or_io_select(rs), .rw(rw), .address_lines(adr), .data_in(din),
    .data_out(dout), .data_oe(oe), .first_port_pins_in(pa_in),
    .first_port_pins_out(pa_out), .first_port_pins_oe(pa_oe),
    .second_port_pins_in(pb_in), .second_port_pins_out(pb_out),
    .second_port_pins_oe(pb_oe), .irq_out(irq_o), .irq_oe(irq_oe));
  rit_host host_i(.clk(clk), .select_high_active(shi),
    .select_low_active(slo), .ram_or_io_select(rs), .rw(rw),
    .address_lines(adr), .data_in(din), .data_out(dout), .data_oe(oe));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic [1:0] cs, input logic r, input logic rd,
      input logic [6:0] ad, input logic [7:0] d, output logic [7:0] v);
    logic [1:0] o;
    host_i.acc(cs, r, rd, ad, d, v, o);
    check("data_oe", {6'h00, o}, {6'h00, rd && cs == 2'b10, 1'b0});
  endtask
  task automatic io(input logic rd, input logic [6:0] ad,
      input logic [7:0] d, output logic [7:0] v);
    bus(2'b10, 1'b1, rd, ad, d, v);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    failures++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    pa_in = 8'hFF;
    pb_in = 8'h00;
    void'($urandom(72));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("pa_oe", pa_oe, 8'h00);
    check("pb_oe", pb_oe, 8'h00);
    check("pa_out", pa_out, 8'h00);
    check("pb_out", pb_out, 8'h00);
    check("irq", {7'h00, irq_oe}, 8'h00);
    check("irq_out", {7'h00, irq_o}, 8'h00);
    check("oe_rst", {7'h00, oe}, 8'h00);
    io(1'b1, 7'h05, 8'h00, q);
    check("flags0", q, 8'h00);
    // port registers through all four offsets
    for (int i = 0; i < 4; i++) begin
      regs[i] = $urandom_range(255);
      io(1'b0, 7'(i), 8'(regs[i]), q);
    end
    check("pa_out", pa_out, 8'(regs[0]));
    check("pa_oe", pa_oe, 8'(regs[1]));
    check("pb_out", pb_out, 8'(regs[2]));
    check("pb_oe", pb_oe, 8'(regs[3]));
    pv = $urandom_range(255) | 8'h80;
    @(posedge clk);
    pa_in <= 8'(pv);
    pb_in <= 8'($urandom_range(255));
    // pins pass two synchroniser flops before a read can see them
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      io(1'b1, 7'(i), 8'h00, q);
      check("port_rd", q, 8'(i == 0 ? pv : regs[i]));
    end
    // ram, then writes that must not land
    for (int i = 0; i < 8; i++) begin
      // last address keeps bit 2 low: the rs-high write must not hit edge control
      a = $urandom_range(127) & (i == 7 ? 'h7B : 'h7F);
      mem[a] = $urandom_range(255);
      bus(2'b10, 1'b0, 1'b0, 7'(a), 8'(mem[a]), q);
    end
    bus(2'b00, 1'b0, 1'b0, 7'(a), 8'(~mem[a]), q);
    bus(2'b11, 1'b0, 1'b0, 7'(a), 8'(~mem[a]), q);
    bus(2'b10, 1'b1, 1'b0, 7'(a), 8'(~mem[a]), q);
    bus(2'b10, 1'b0, 1'b1, 7'(a), 8'h00, q);
    check("ram", q, 8'(mem[a]));
    io(1'b1, 7'h05, 8'h00, q);
    // timer at every prescale
    for (int k = 0; k < 4; k++) begin
      n = dv[k] == 1 ? $urandom_range(40, 20) : $urandom_range(4, 2);
      io(1'b0, 7'h1C | 7'(k), 8'(n), q);
      t0 = cyc;
      if (dv[k] > 1) begin
        repeat (dv[k] + dv[k] / 2 - 3) @(posedge clk);
        io(1'b1, 7'h0C, 8'h00, q);
        check("count", q, 8'(n - 1));
      end
      while (irq_oe !== 1'b1 && cyc - t0 < 6000) begin
        @(posedge clk);
        #1;
      end
      a = cyc - t0;
      check("tmo", 8'(a >= (n + 1) * dv[k] - 4 && a <= (n + 1) * dv[k] + 3),
        8'h01);
      io(1'b1, 7'h05, 8'h00, q);
      check("tflag", q, 8'h80);
      io(1'b1, 7'h04, 8'h00, q);
      check("after", {5'h00, q[7:5]}, 8'h07);
      check("irq_off", {7'h00, irq_oe}, 8'h00);
      io(1'b1, 7'h05, 8'h00, q);
      check("tclr", q, 8'h00);
    end
    // edge sense on the top port A pin, reset setup first
    @(posedge clk);
    pa_in <= 8'(pv) & 8'h7F;
    repeat (6) @(posedge clk);
    check("irq_dis", {7'h00, irq_oe}, 8'h00);
    io(1'b1, 7'h05, 8'h00, q);
    check("efall", q, 8'h40);
    io(1'b1, 7'h05, 8'h00, q);
    check("eclr", q, 8'h00);
    io(1'b0, 7'h07, 8'($urandom_range(255)), q);
    io(1'b1, 7'h05, 8'h00, q);
    @(posedge clk);
    pa_in <= 8'(pv);
    repeat (6) @(posedge clk);
    check("irq_edge", {7'h00, irq_oe}, 8'h01);
    io(1'b1, 7'h05, 8'h00, q);
    check("erise", q, 8'h40);
    check("irq_clr", {7'h00, irq_oe}, 8'h00);
    @(posedge clk);
    pa_in <= 8'(pv) & 8'h7F;
    repeat (6) @(posedge clk);
    io(1'b1, 7'h05, 8'h00, q);
    check("epol", q, 8'h00);
    // mid-run reset with the pin low: enables drop, a false edge is flagged
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("pa_oe_rst", pa_oe, 8'h00);
    check("pb_out_rst", pb_out, 8'h00);
    repeat (6) @(posedge clk);
    check("irq_rst", {7'h00, irq_oe}, 8'h00);
    io(1'b1, 7'h05, 8'h00, q);
    check("eflag_rst", q, 8'h40);
    complete_run();
  end
endmodule

/* File: tb/rit_host.sv */
// Purpose: processor side of the system bus, one access per task call
// Assumes: an access is taken at the edge after the request is driven
// Notes: released bus lines toggle so stale values are never reused
module rit_host
  import rit_pkg::*;
(
  input wire logic clk,
  output logic select_high_active,
  output logic select_low_active,
  output logic ram_or_io_select,
  output logic rw,
  output logic [RIT_AW-1:0] address_lines,
  output logic [RIT_DW-1:0] data_in,
  input wire logic [RIT_DW-1:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    select_high_active = 1'b0;
    select_low_active = 1'b1;
    ram_or_io_select = 1'b1;
    rw = 1'b1;
    address_lines = 7'h00;
    data_in = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // cs is {high select, low select}; oe returns {at answer, after}
  task automatic acc(input logic [1:0] cs, input logic rs, input logic rd,
      input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
      output logic [1:0] oe);
    @(posedge clk);
    select_high_active <= cs[1];
    select_low_active <= cs[0];
    ram_or_io_select <= rs;
    rw <= rd;
    address_lines <= a;
    data_in <= d;
    @(posedge clk);
    select_high_active <= 1'b0;
    select_low_active <= 1'b1;
    address_lines <= ~a;
    data_in <= ~d;
    // read data stand for one cycle only, right after the next edge
    @(posedge clk);
    #1;
    q = data_out;
    oe[1] = data_oe;
    @(posedge clk);
    #1;
    oe[0] = data_oe;
  endtask
endmodule
